/* File: logic/rdvs_pkg.sv */
package rdvs_pkg;

  // =====================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_CORE0  = 8'h00;
  localparam logic [7:0] ADDR_CORE1  = 8'h04;
  localparam logic [7:0] ADDR_BUCK3  = 8'h08;
  localparam logic [7:0] ADDR_BUCK4  = 8'h0C;
  localparam logic [7:0] ADDR_BUCK5  = 8'h10;
  localparam logic [7:0] ADDR_BOOST  = 8'h14;
  localparam logic [7:0] ADDR_LDO    = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_SETPT  = 8'h20;
  localparam int unsigned NUM_CFG    = 7;

  // =====================================================================
  // field positions
  localparam int unsigned SP_NORM_LSB  = 0;   // normal set point [4:0]
  localparam int unsigned SP_STBY_LSB  = 8;   // standby set point [12:8]
  localparam int unsigned SPEED_LSB    = 16;  // step speed [17:16]
  localparam int unsigned HIRNG_LSB    = 8;   // buck four range [9:8]
  localparam int unsigned SLOW_BIT     = 12;  // buck four 16 us pacing
  localparam int unsigned BST_V_LSB    = 0;
  localparam int unsigned BST_MN_LSB   = 2;
  localparam int unsigned BST_MS_LSB   = 4;
  localparam int unsigned LDO_FLD_W    = 3;   // {stby, mode, en} per ldo
  localparam int unsigned GPO_STBY_BIT = 24;
  localparam int unsigned SCP_EN_BIT   = 28;
  localparam int unsigned NUM_LDO      = 6;
  localparam int unsigned NUM_BUCK     = 5;

  // writable bits of each config word
  localparam logic [31:0] WMASK_CORE  = 32'h0003_1F1F;
  localparam logic [31:0] WMASK_B35   = 32'h0000_001F;
  localparam logic [31:0] WMASK_B4    = 32'h0000_131F;
  localparam logic [31:0] WMASK_BOOST = 32'h0000_003F;
  localparam logic [31:0] WMASK_LDO   = 32'h1103_FFFF;

  // =====================================================================
  // reset values
  localparam logic [31:0] RST_CORE  = 32'h0001_0000; // speed code 01
  localparam logic [31:0] RST_B35   = 32'h0000_0000;
  localparam logic [31:0] RST_BOOST = 32'h0000_0028; // 5.000 V, auto
  localparam logic [31:0] RST_LDO   = 32'h0000_0000;

  // =====================================================================
  // enumerations
  localparam logic [1:0] BST_OFF  = 2'h0;
  localparam logic [1:0] BST_PFM  = 2'h1;
  localparam logic [1:0] BST_AUTO = 2'h2;
  localparam logic [1:0] BST_PWM  = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ldo order: dac, usb two, general two (external), pll, general one,
  // usb (internal pass)
  localparam logic [5:0] LDO_EXT_MASK = 6'h07;
  localparam logic [5:0] LDO_SCP_MASK = 6'h37; // all but pll supply

  // =====================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned STEP_2US_NS   = 2000;
  localparam int unsigned STEP_4US_NS   = 4000;
  localparam int unsigned STEP_8US_NS   = 8000;
  localparam int unsigned STEP_16US_NS  = 16000;
  localparam logic [9:0] CYC_2US  = 10'(STEP_2US_NS / CLK_PERIOD_NS);
  localparam logic [9:0] CYC_4US  = 10'(STEP_4US_NS / CLK_PERIOD_NS);
  localparam logic [9:0] CYC_8US  = 10'(STEP_8US_NS / CLK_PERIOD_NS);
  localparam logic [9:0] CYC_16US = 10'(STEP_16US_NS / CLK_PERIOD_NS);

  // =====================================================================
  // carriers
  typedef struct packed {
    logic [5:0] on;
    logic [5:0] low_power;
    logic [5:0] pull_down;
  } rdvs_ldo_out_t;

  typedef struct packed {
    logic [1:0] voltage_select;
    logic [1:0] mode;
  } rdvs_boost_out_t;

endpackage : rdvs_pkg

/* File: logic/rdvs_top.sv */
module rdvs_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // axi4-lite slave
  input  wire logic [7:0]                s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [7:0]                s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  // device side
  input  wire logic                      standby_i,
  input  wire logic                      system_reset_n_i,
  input  wire logic [1:0]                buck_current_limit_i,
  input  wire logic [5:0]                ldo_short_circuit_i,
  output logic [24:0]                    buck_setpoint_o,
  output logic [1:0]                     buck4_high_range_select_o,
  output logic [1:0]                     buck_power_good_pin_o,
  output rdvs_pkg::rdvs_boost_out_t      boost_o,
  output rdvs_pkg::rdvs_ldo_out_t        ldo_o,
  output logic                           gpo_force_low_o,
  output logic                           scp_event_o
);

  // =====================================================================
  // helpers

  // step interval in clock cycles for a two-bit speed code
  function automatic logic [9:0] speed_cycles(input logic [1:0] code);
    logic [9:0] c;
    case (code)
      2'h0: c = rdvs_pkg::CYC_2US;
      2'h1: c = rdvs_pkg::CYC_4US;
      2'h2: c = rdvs_pkg::CYC_8US;
      default: c = rdvs_pkg::CYC_16US;
    endcase
    return c;
  endfunction : speed_cycles

  // byte-lane merge limited to the writable bits
  function automatic logic [31:0] merge_wr(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  strb,
                                           input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~m) | (wd & m);
  endfunction : merge_wr

  // =====================================================================
  // axi write channel: address and data taken in either order
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic        wr_hit;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;

  // ready is low while a word is held, so each is taken exactly once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_have_q       <= 1'b0;
      w_have_q        <= 1'b0;
      awaddr_q        <= 8'h00;
      wdata_q         <= 32'h0000_0000;
      wstrb_q         <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_have_q && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o  <= !w_have_q && !(s_axi_wvalid_i && s_axi_wready_o);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response; unmapped or read-only words answer slave error
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= rdvs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? rdvs_pkg::RESP_OKAY
                               : rdvs_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // =====================================================================
  // configuration words
  logic [31:0] cfg_q [rdvs_pkg::NUM_CFG];
  logic [2:0]  wr_idx;
  logic [31:0] wr_mask;
  logic [5:0]  scp_kill;
  logic [5:0]  ldo_en;

  // address decode for writes
  always_comb begin
    wr_hit  = 1'b1;
    wr_idx  = 3'h0;
    wr_mask = rdvs_pkg::WMASK_CORE;
    if (awaddr_q == rdvs_pkg::ADDR_CORE0) begin
      wr_idx = 3'h0;
    end else if (awaddr_q == rdvs_pkg::ADDR_CORE1) begin
      wr_idx = 3'h1;
    end else if (awaddr_q == rdvs_pkg::ADDR_BUCK3) begin
      wr_idx  = 3'h2;
      wr_mask = rdvs_pkg::WMASK_B35;
    end else if (awaddr_q == rdvs_pkg::ADDR_BUCK4) begin
      wr_idx  = 3'h3;
      wr_mask = rdvs_pkg::WMASK_B4;
    end else if (awaddr_q == rdvs_pkg::ADDR_BUCK5) begin
      wr_idx  = 3'h4;
      wr_mask = rdvs_pkg::WMASK_B35;
    end else if (awaddr_q == rdvs_pkg::ADDR_BOOST) begin
      wr_idx  = 3'h5;
      wr_mask = rdvs_pkg::WMASK_BOOST;
    end else if (awaddr_q == rdvs_pkg::ADDR_LDO) begin
      wr_idx  = 3'h6;
      wr_mask = rdvs_pkg::WMASK_LDO;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // short circuit clears the enable bit only when protection is on
  always_comb begin
    for (int k = 0; k < rdvs_pkg::NUM_LDO; k++) begin
      ldo_en[k] = cfg_q[6][k*rdvs_pkg::LDO_FLD_W];
    end
    scp_kill = ldo_short_circuit_i & rdvs_pkg::LDO_SCP_MASK & ldo_en
             & {6{cfg_q[6][rdvs_pkg::SCP_EN_BIT]}};
  end

  // software writes; the hardware disable wins over a same-cycle write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q[0] <= rdvs_pkg::RST_CORE;
      cfg_q[1] <= rdvs_pkg::RST_CORE;
      cfg_q[2] <= rdvs_pkg::RST_B35;
      cfg_q[3] <= rdvs_pkg::RST_B35;
      cfg_q[4] <= rdvs_pkg::RST_B35;
      cfg_q[5] <= rdvs_pkg::RST_BOOST;
      cfg_q[6] <= rdvs_pkg::RST_LDO;
    end else begin
      for (int i = 0; i < rdvs_pkg::NUM_CFG; i++) begin
        if (wr_fire && wr_hit && (wr_idx == 3'(i))) begin
          cfg_q[i] <= merge_wr(cfg_q[i], wdata_q, wstrb_q, wr_mask);
        end
      end
      for (int k = 0; k < rdvs_pkg::NUM_LDO; k++) begin
        if (scp_kill[k]) begin
          cfg_q[6][k*rdvs_pkg::LDO_FLD_W] <= 1'b0;
        end
      end
    end
  end

  // one-cycle event toward the system interrupt controller
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scp_event_o <= 1'b0;
    end else begin
      scp_event_o <= |scp_kill;
    end
  end

  // =====================================================================
  // set point sequencers, one per buck
  logic [4:0] target   [rdvs_pkg::NUM_BUCK];
  logic [9:0] interval [rdvs_pkg::NUM_BUCK];
  logic [4:0] cur_q    [rdvs_pkg::NUM_BUCK];
  logic [4:0] tgt_q    [rdvs_pkg::NUM_BUCK];
  logic [9:0] tmr_q    [rdvs_pkg::NUM_BUCK];
  logic [4:0] busy;

  // target and pacing selection per buck
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      target[b] = standby_i ? cfg_q[b][rdvs_pkg::SP_STBY_LSB +: 5]
                            : cfg_q[b][rdvs_pkg::SP_NORM_LSB +: 5];
      interval[b] = speed_cycles(cfg_q[b][rdvs_pkg::SPEED_LSB +: 2]);
    end
    target[2]   = cfg_q[2][rdvs_pkg::SP_NORM_LSB +: 5];
    interval[2] = rdvs_pkg::CYC_4US;
    target[3]   = cfg_q[3][rdvs_pkg::SP_NORM_LSB +: 5];
    interval[3] = cfg_q[3][rdvs_pkg::SLOW_BIT] ? rdvs_pkg::CYC_16US
                                               : rdvs_pkg::CYC_8US;
    target[4]   = cfg_q[4][rdvs_pkg::SP_NORM_LSB +: 5];
    interval[4] = rdvs_pkg::CYC_4US;
    for (int b = 0; b < rdvs_pkg::NUM_BUCK; b++) begin
      busy[b] = (cur_q[b] != target[b]);
    end
  end

  // a changed target reloads the timer and stepping resumes from the
  // present point, so the output never jumps
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int b = 0; b < rdvs_pkg::NUM_BUCK; b++) begin
        cur_q[b] <= 5'h00;
        tgt_q[b] <= 5'h00;
        tmr_q[b] <= 10'h000;
      end
    end else begin
      for (int b = 0; b < rdvs_pkg::NUM_BUCK; b++) begin
        tgt_q[b] <= target[b];
        if (!busy[b] || (target[b] != tgt_q[b])) begin
          tmr_q[b] <= interval[b] - 10'h001;
        end else if (tmr_q[b] == 10'h000) begin
          tmr_q[b] <= interval[b] - 10'h001;
          if (cur_q[b] < target[b]) begin
            cur_q[b] <= cur_q[b] + 5'h01;
          end else begin
            cur_q[b] <= cur_q[b] - 5'h01;
          end
        end else begin
          tmr_q[b] <= tmr_q[b] - 10'h001;
        end
      end
    end
  end

  // present set points and buck four range toward the analog side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buck_setpoint_o           <= 25'h000_0000;
      buck4_high_range_select_o <= 2'h0;
    end else begin
      buck_setpoint_o <= {cur_q[4], cur_q[3], cur_q[2], cur_q[1], cur_q[0]};
      buck4_high_range_select_o <= cfg_q[3][rdvs_pkg::HIRNG_LSB +: 2];
    end
  end

  // power good: low while stepping whatever the current limit says, and
  // outside stepping held low as long as the limit lasts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buck_power_good_pin_o <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        buck_power_good_pin_o[b] <= !busy[b]
                                  && !buck_current_limit_i[b];
      end
    end
  end

  // =====================================================================
  // boost control; codes pass straight to the converter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boost_o <= '{voltage_select: 2'h0, mode: rdvs_pkg::BST_AUTO};
    end else begin
      boost_o.voltage_select <= cfg_q[5][rdvs_pkg::BST_V_LSB +: 2];
      boost_o.mode <= standby_i ? cfg_q[5][rdvs_pkg::BST_MS_LSB +: 2]
                                : cfg_q[5][rdvs_pkg::BST_MN_LSB +: 2];
    end
  end

  // =====================================================================
  // ldo truth tables
  logic [5:0] ldo_on;
  logic [5:0] ldo_lp;

  always_comb begin
    for (int k = 0; k < rdvs_pkg::NUM_LDO; k++) begin
      logic en, md, sb;
      en = cfg_q[6][k*rdvs_pkg::LDO_FLD_W];
      md = cfg_q[6][k*rdvs_pkg::LDO_FLD_W + 1];
      sb = cfg_q[6][k*rdvs_pkg::LDO_FLD_W + 2];
      if (rdvs_pkg::LDO_EXT_MASK[k]) begin
        // external pass: mode bit keeps it up in low power
        ldo_on[k] = en && (md || !(sb && standby_i));
        ldo_lp[k] = en && md && (!sb || standby_i);
      end else begin
        // internal pass: no low power state exists
        ldo_on[k] = en && !(sb && standby_i);
        ldo_lp[k] = 1'b0;
      end
    end
  end

  // operating state is output only; reads never see it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ldo_o           <= '{on: 6'h00, low_power: 6'h00, pull_down: 6'h3F};
      gpo_force_low_o <= 1'b0;
    end else begin
      ldo_o.on        <= ldo_on;
      ldo_o.low_power <= ldo_lp;
      ldo_o.pull_down <= ~ldo_on | {6{!system_reset_n_i}};
      gpo_force_low_o <= cfg_q[6][rdvs_pkg::GPO_STBY_BIT] && standby_i;
    end
  end

  // =====================================================================
  // axi read channel: one cycle after the address is taken
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr_i == rdvs_pkg::ADDR_CORE0) begin
      rd_word = cfg_q[0];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_CORE1) begin
      rd_word = cfg_q[1];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_BUCK3) begin
      rd_word = cfg_q[2];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_BUCK4) begin
      rd_word = cfg_q[3];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_BUCK5) begin
      rd_word = cfg_q[4];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_BOOST) begin
      rd_word = cfg_q[5];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_LDO) begin
      rd_word = cfg_q[6];
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_STATUS) begin
      rd_word = {3'h0, busy, 16'h0000, 6'h00, buck_power_good_pin_o};
    end else if (s_axi_araddr_i == rdvs_pkg::ADDR_SETPT) begin
      rd_word = {2'h0, 1'b0, cur_q[4], 1'b0, cur_q[3], 1'b0, cur_q[2],
                 1'b0, cur_q[1], 1'b0, cur_q[0]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // arready held low while a read answer waits for the master
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= rdvs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word;
        s_axi_rresp_o   <= rd_hit ? rdvs_pkg::RESP_OKAY
                                  : rdvs_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o) begin
        if (s_axi_rready_i) begin
          s_axi_rvalid_o  <= 1'b0;
          s_axi_arready_o <= 1'b1;
        end
      end else begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule : rdvs_top

/* File: bench/rdvs_properties.sv */
module rdvs_properties (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    s_axi_arvalid_i,
  input  wire logic                    s_axi_arready_o,
  input  wire logic                    s_axi_rvalid_o,
  input  wire logic                    s_axi_rready_i,
  input  wire logic [31:0]             s_axi_rdata_o,
  input  wire logic                    standby_i,
  input  wire logic                    system_reset_n_i,
  input  wire logic [1:0]              buck_current_limit_i,
  input  wire logic [5:0]              ldo_short_circuit_i,
  input  wire logic [24:0]             buck_setpoint_o,
  input  wire logic [1:0]              buck_power_good_pin_o,
  input  wire rdvs_pkg::rdvs_ldo_out_t ldo_o,
  input  wire logic                    gpo_force_low_o,
  input  wire logic                    scp_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========
  // cycles since the last step, saturating so idle bucks never trip
  logic [9:0] gap0_q;
  logic [9:0] gap4_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) gap0_q <= 10'h3FF;
    else if ($changed(buck_setpoint_o[4:0])) gap0_q <= 10'h000;
    else if (gap0_q != 10'h3FF) gap0_q <= gap0_q + 10'h001;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) gap4_q <= 10'h3FF;
    else if ($changed(buck_setpoint_o[19:15])) gap4_q <= 10'h000;
    else if (gap4_q != 10'h3FF) gap4_q <= gap4_q + 10'h001;
  end

  sequence s_core_step;
    $changed(buck_setpoint_o[4:0]);
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  // ==========
  chk_step_unit: assert property (s_core_step |->
    5'(buck_setpoint_o[4:0] - $past(buck_setpoint_o[4:0])) inside {5'h01, 5'h1F})
    else $error("core set point jumped by more than one code");
  chk_core_gap: assert property (s_core_step |-> gap0_q >= 10'h04F)
    else $error("core step came sooner than the fastest interval");
  chk_b4_gap: assert property ($changed(buck_setpoint_o[19:15]) |->
    gap4_q >= 10'h13F) else $error("buck four step came too soon");
  chk_pg_step: assert property (s_core_step |->
    !$past(buck_power_good_pin_o[0])) else $error("power good up at a step");
  chk_pg_limit: assert property (buck_current_limit_i[0] |=>
    !buck_power_good_pin_o[0]) else $error("power good high at limit");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
    else $error("read data not offered one cycle after address");
  chk_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data moved");
  chk_gpo_cause: assert property (gpo_force_low_o |-> $past(standby_i))
    else $error("outputs forced low outside standby");
  chk_pd_sysrst: assert property (!system_reset_n_i |=>
    ldo_o.pull_down == 6'h3F) else $error("pull down off in system reset");
  chk_pd_off: assert property ((ldo_o.pull_down | ldo_o.on) == 6'h3F)
    else $error("disabled regulator without pull down");
  chk_scp_cause: assert property (scp_event_o |->
    $past(|ldo_short_circuit_i)) else $error("short event without a short");
  chk_int_lp: assert property (ldo_o.low_power[5:3] == 3'h0)
    else $error("internal pass regulator in low power");
endmodule : rdvs_properties

bind rdvs_top rdvs_properties rdvs_properties_inst (.clk_i, .rst_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_rdata_o, .standby_i, .system_reset_n_i, .buck_current_limit_i,
  .ldo_short_circuit_i, .buck_setpoint_o, .buck_power_good_pin_o, .ldo_o,
  .gpo_force_low_o, .scp_event_o);

/* File: bench/rdvs_proc_model.sv */
module rdvs_proc_model (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // processor side idles with every request low
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'hF;
  end
  // each channel drops its valid only at the edge its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end while (bvalid_i !== 1'b1);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end while (rvalid_i !== 1'b1);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask : rd
endmodule : rdvs_proc_model

/* File: bench/rdvs_top_test.sv */
module rdvs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, standby_i = 1'b0, system_reset_n_i = 1'b1;
  logic [1:0] buck_current_limit_i = 2'h0;
  logic [5:0] ldo_short_circuit_i = 6'h00;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt, v;
  logic [3:0] ws;
  logic [1:0] br, rr, hr, pg;
  logic aw, awr, w, wr_, bv, bre, ar, arr, rv, rre, gpo, short_circuit_protection, e, m, s, b;
  logic [24:0] sp;
  rdvs_pkg::rdvs_boost_out_t bst;
  rdvs_pkg::rdvs_ldo_out_t ldo;
  int n_errors = 0, compares = 0;
  logic [7:0] ba[4] = '{rdvs_pkg::ADDR_BUCK3, rdvs_pkg::ADDR_BUCK5,
                        rdvs_pkg::ADDR_BUCK4, rdvs_pkg::ADDR_BUCK4};
  int bl[4] = '{10, 20, 15, 15}, bn[4] = '{320, 320, 640, 1280};
  logic [31:0] bd[4] = '{32'h2, 32'h2, 32'h2, 32'h1300};

  always #12.5 clk_i = ~clk_i;

  rdvs_top rdvs_top_inst (.clk_i, .rst_i, .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(aw), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(w), .s_axi_wready_o(wr_),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(ar), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .standby_i, .system_reset_n_i,
    .buck_current_limit_i, .ldo_short_circuit_i, .buck_setpoint_o(sp),
    .buck4_high_range_select_o(hr), .buck_power_good_pin_o(pg),
    .boost_o(bst), .ldo_o(ldo), .gpo_force_low_o(gpo), .scp_event_o(short_circuit_protection));
  rdvs_proc_model rdvs_proc_model_inst (.clk_i, .awaddr_o(awa),
    .awvalid_o(aw), .awready_i(awr), .wdata_o(wd), .wstrb_o(ws),
    .wvalid_o(w), .wready_i(wr_), .bresp_i(br), .bvalid_i(bv),
    .bready_o(bre), .araddr_o(ara), .arvalid_o(ar), .arready_i(arr),
    .rdata_i(rdt), .rresp_i(rr), .rvalid_i(rv), .rready_o(rre));

  // ==========
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    rdvs_proc_model_inst.wr(a, d, r);
    check(32'(r), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic [1:0] r;
    rdvs_proc_model_inst.rd(a, v, r);
    check(v, ex);
    check(32'(r), 32'(rdvs_pkg::RESP_OKAY));
  endtask : rd
  // settled sampling: one tick past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // time from the write answer to the last step, with slack for latency
  task automatic settle(input int lsb, input logic [4:0] t, input int n);
    int c;
    c = 0;
    while (sp[lsb+:5] !== t && c < 5000) begin
      tick(1);
      c++;
    end
    check(32'(c >= n - 8 && c <= n + 8), 32'h1);
  endtask : settle
  task automatic stop_test;
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // ==========
  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    check(32'({bst, pg}), 32'h0B);
    rd(rdvs_pkg::ADDR_CORE0, rdvs_pkg::RST_CORE);
    rd(rdvs_pkg::ADDR_BOOST, rdvs_pkg::RST_BOOST);
    wr(8'h24, 32'h1, rdvs_pkg::RESP_SLVERR);
    wr(rdvs_pkg::ADDR_STATUS, 32'h1, rdvs_pkg::RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      wr(rdvs_pkg::ADDR_CORE0, 32'(k) << 16 | 32'(~k & 1), 2'h0);
      tick(3);
      check(32'(pg[0]), 32'h0);
      settle(0, 5'(~k & 1), 80 << k);
      tick(2);
      check(32'(pg[0]), 32'h1);
    end
    wr(rdvs_pkg::ADDR_CORE0, 32'h0200, 2'h0);
    standby_i <= 1'b1;
    settle(0, 5'h02, 160);
    @(posedge clk_i);
    standby_i <= 1'b0;
    settle(0, 5'h00, 160);
    wr(rdvs_pkg::ADDR_CORE0, 32'h3, 2'h0);
    tick(100);
    wr(rdvs_pkg::ADDR_CORE0, 32'h0, 2'h0);
    settle(0, 5'h00, 79);
    buck_current_limit_i <= 2'h1;
    tick(3);
    check(32'(pg), 32'h2);
    @(posedge clk_i);
    buck_current_limit_i <= 2'h0;
    tick(3);
    check(32'(pg), 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(ba[i], bd[i], 2'h0);
      settle(bl[i], 5'(bd[i]), bn[i]);
      check(32'(hr), 32'(bd[i][9:8]));
    end
    for (int k = 0; k < 4; k++) begin
      wr(rdvs_pkg::ADDR_BOOST, 32'(k) * 32'h5 + 32'(3 - k) * 32'h10, 2'h0);
      tick(2);
      check(32'(bst), 32'(k) * 32'h5);
      @(posedge clk_i);
      standby_i <= 1'b1;
      tick(3);
      check(32'(bst.mode), 32'(3 - k));
      rd(rdvs_pkg::ADDR_BOOST, 32'(k) * 32'h5 + 32'(3 - k) * 32'h10);
      standby_i <= 1'b0;
    end
    for (int k = 0; k < 16; k++) begin
      {b, s, m, e} = 4'(k);
      @(posedge clk_i);
      standby_i <= b;
      wr(rdvs_pkg::ADDR_LDO, 32'({s, m, e}) * 32'h8049 | 32'h0100_0000, 2'h0);
      tick(3);
      check(32'({ldo.on[2:0], ldo.low_power[2:0], ldo.on[5], ldo.pull_down[0],
        gpo}), 32'({{3{e && !(s && b && !m)}}, {3{e && m && (!s || b)}},
        e && !(s && b), !(e && !(s && b && !m)), b}));
      rd(rdvs_pkg::ADDR_LDO, 32'({s, m, e}) * 32'h8049 | 32'h0100_0000);
    end
    system_reset_n_i <= 1'b0;
    standby_i <= 1'b0;
    tick(3);
    check(32'(ldo.pull_down), 32'h3F);
    @(posedge clk_i);
    system_reset_n_i <= 1'b1;
    wr(rdvs_pkg::ADDR_LDO, 32'h1000_0001, 2'h0);
    ldo_short_circuit_i <= 6'h01;
    for (int c = 0; c < 10 && short_circuit_protection !== 1'b1; c++) tick(1);
    check(32'({short_circuit_protection, ldo.on[0]}), 32'h3);
    ldo_short_circuit_i <= 6'h00;
    rd(rdvs_pkg::ADDR_LDO, 32'h1000_0000);
    check(32'({short_circuit_protection, ldo.on[0]}), 32'h0);
    stop_test();
  end
endmodule : rdvs_top_test
